// file: fbc_alu.v
// Four-bit ALU for the core: add, subtract, logic, compare and bit test.
// Assumes op_a read straight from data memory, op_b from memory or the instruction's low field; purely combinational.
`timescale 1ns/10ps
`default_nettype none
`include "fbc_consts.vh"
module fbc_alu (
  // Operands
  input wire [5:0] opcode,
  input wire [3:0] op_a,
  input wire [3:0] op_b,
  input wire carry_in,
  // Results
  output reg [3:0] result,
  output reg carry_out,
  output reg skip_cond,
  output reg writes_carry
);
  reg [4:0] sum;
  // ==========================================
  // Operation select; op_a is memory or register, op_b the other operand
  always @* begin
    sum = 5'h00;
    result = op_a;
    carry_out = carry_in;
    skip_cond = 1'b0;
    writes_carry = 1'b0;
    case (opcode)
      `OP_AI, `OP_ADD_IMM_SKIP, `OP_AIN, `OP_AD, `OP_ADS, `OP_ADN: begin
        sum = {1'b0, op_a} + {1'b0, op_b};
      end
      `OP_AIC, `OP_AICS, `OP_AICN, `OP_AC, `OP_ACS, `OP_ACN: begin
        sum = {1'b0, op_a} + {1'b0, op_b} + {4'h0, carry_in};
      end
      `OP_SI, `OP_SIS, `OP_SIN, `OP_SU, `OP_SUS, `OP_SUN: begin
        sum = {1'b0, op_a} - {1'b0, op_b};
      end
      `OP_SIB, `OP_SIBS, `OP_SIBN, `OP_SB, `OP_SBS, `OP_SBN: begin
        sum = {1'b0, op_a} - {1'b0, op_b} - {4'h0, carry_in};
      end
      default: begin
        sum = 5'h00;
      end
    endcase
    case (opcode)
      `OP_AI, `OP_ADD_IMM_SKIP, `OP_AIN, `OP_AD, `OP_ADS, `OP_ADN, `OP_AIC, `OP_AICS,
      `OP_AICN, `OP_AC, `OP_ACS, `OP_ACN, `OP_SI, `OP_SIS, `OP_SIN, `OP_SU,
      `OP_SUS, `OP_SUN, `OP_SIB, `OP_SIBS, `OP_SIBN, `OP_SB, `OP_SBS,
      `OP_SBN: begin
        result = sum[3:0]; // RULE7
        carry_out = sum[4]; // RULE16
        writes_carry = 1'b1; // RULE17
      end
      `OP_ORR, `OP_ORIM: result = op_a | op_b;
      `OP_ANDR, `OP_ANIM: result = op_a & op_b;
      default: result = op_a;
    endcase
    // Skip judge; bit-test masks use op_b as the bit pattern
    case (opcode)
      `OP_ADD_IMM_SKIP, `OP_AICS, `OP_ADS, `OP_ACS, `OP_SIS, `OP_SIBS, `OP_SUS,
      `OP_SBS: skip_cond = sum[4]; // RULE19
      `OP_AIN, `OP_AICN, `OP_ADN, `OP_ACN, `OP_SIN, `OP_SIBN, `OP_SUN,
      `OP_SBN: skip_cond = ~sum[4];
      `OP_SLTI, `OP_LESS_THAN_SKIP: skip_cond = (op_a < op_b);
      `OP_SGEI, `OP_SGE: skip_cond = (op_a >= op_b);
      `OP_SEQI, `OP_SEQ: skip_cond = (op_a == op_b);
      `OP_SNEI, `OP_SNE: skip_cond = (op_a != op_b);
      `OP_BIT_TEST_TRUE, `OP_TMTR: skip_cond = ((op_a & op_b) == op_b);
      `OP_TMF, `OP_TMFR: skip_cond = ((op_a & op_b) == 4'h0);
      default: skip_cond = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: fbc_consts.vh
// Constants for the four-bit core: widths, reset values, opcode encodings.
// Assumes inclusion by bare name from each design file.
`ifndef FBC_CONSTS_VH
`define FBC_CONSTS_VH
// ==========================================
// Widths and reset values
`define FBC_PC_W 10
`define FBC_PC_RST 10'h000
`define FBC_ROW_W 3
`define FBC_COL_W 4
`define FBC_NIB_W 4
`define FBC_WORD_W 16
`define FBC_G_RST 3'h0
`define FBC_DATA_RST 16'h0000
// ==========================================
// Instruction word fields
`define FBC_IC_HI 15
`define FBC_IC_LO 10
`define FBC_ROW_HI 9
`define FBC_ROW_LO 8
`define FBC_COL_HI 7
`define FBC_COL_LO 4
`define FBC_LO_HI 3
`define FBC_LO_LO 0
`define FBC_ADDR_HI 9
`define FBC_ADDR_LO 0
// ==========================================
// Opcodes
`define OP_AI 6'h00
`define OP_ADD_IMM_SKIP 6'h01
`define OP_AIN 6'h02
`define OP_SI 6'h03
`define OP_SIS 6'h04
`define OP_SIN 6'h05
`define OP_CAL 6'h06
`define OP_UND0 6'h07
`define OP_AIC 6'h08
`define OP_AICS 6'h09
`define OP_AICN 6'h0a
`define OP_SIB 6'h0b
`define OP_SIBS 6'h0c
`define OP_SIBN 6'h0d
`define OP_JUMP 6'h0e
`define OP_UND1 6'h0f
`define OP_AD 6'h10
`define OP_ADS 6'h11
`define OP_ADN 6'h12
`define OP_SU 6'h13
`define OP_SUS 6'h14
`define OP_SUN 6'h15
`define OP_ORR 6'h16
`define OP_ANDR 6'h17
`define OP_AC 6'h18
`define OP_ACS 6'h19
`define OP_ACN 6'h1a
`define OP_SB 6'h1b
`define OP_SBS 6'h1c
`define OP_SBN 6'h1d
`define OP_ORIM 6'h1e
`define OP_ANIM 6'h1f
`define OP_LD 6'h20
`define OP_ST 6'h21
`define OP_MVRD 6'h22
`define OP_MVRS 6'h23
`define OP_MVSR 6'h24
`define OP_MVIM 6'h25
`define OP_INDIRECT_LOAD 6'h26
`define OP_INDIRECT_STORE 6'h27
`define OP_PLL 6'h28
`define OP_SEG 6'h29
`define OP_AMRK 6'h2a
`define OP_IO 6'h2b
`define OP_KEY 6'h2c
`define OP_SIO 6'h2d
`define OP_RETURN 6'h2e
`define OP_RETURN_SKIP 6'h2f
`define OP_SLTI 6'h30
`define OP_SGEI 6'h31
`define OP_SEQI 6'h32
`define OP_SNEI 6'h33
`define OP_LESS_THAN_SKIP 6'h34
`define OP_SGE 6'h35
`define OP_SEQ 6'h36
`define OP_SNE 6'h37
`define OP_TMTR 6'h38
`define OP_TMFR 6'h39
`define OP_BIT_TEST_TRUE 6'h3a
`define OP_TMF 6'h3b
`define OP_TABLE_READ 6'h3c
`define OP_WAIT 6'h3d
`define OP_CLOCK_HALT 6'h3e
`define OP_NO_OPERATION 6'h3f
// ==========================================
// Port codes written by the port output instruction
`define FBC_PORT_G 4'h0
`endif

// file: fbc_core.v
// Four-bit core: program counter, one-level stack, ROM, RAM, G and data
// registers, carry and skip judge. One instruction per enabled clock unless halted.
// Assumes the ROM image is loaded by the surrounding logic over rom_wr_*.
`timescale 1ns/10ps
`default_nettype none
`include "fbc_consts.vh"
// Contract
// RULE1 - Ten-bit program counter cleared by reset
// RULE2 - Increment by one; jump and call load
// RULE3 - Skip condition true advances counter by two
// RULE4 - Call saves counter plus one in stack
// RULE5 - Both returns reload counter from stack
// RULE6 - Single stack level; nested call overwrites
// RULE7 - Four-bit ALU works directly on memory
// RULE8 - ROM 1024 sixteen-bit words, unpaged targets
// RULE9 - Table read loads full word into data
// RULE10 - RAM 128 nibbles, row and column
// RULE11 - Rows four to seven via G register
// RULE12 - Words zero to fifteen are general registers
// RULE13 - G register used only by indirect transfers
// RULE14 - G register written only by port output
// RULE15 - Key input reads data register by nibbles
// RULE16 - Carry set on carry or borrow, else cleared
// RULE17 - Carry held by non-arithmetic instructions
// RULE18 - Decode 62 instructions by six-bit code
// RULE19 - Judge evaluates skip-capable instructions, double increment
// RULE20 - Low initialize input holds core in reset
// RULE21 - Clock halt is no-op when inhibit high
// RULE22 - Unassigned codes act as no-operation
module fbc_core #(
  parameter PC_W = `FBC_PC_W,
  parameter WORD_W = `FBC_WORD_W
) (
  // Clock, reset, enable
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  // Pins
  input wire init_n_in,
  input wire inhibit_in,
  // Program memory loading
  input wire rom_wr_en,
  input wire [PC_W-1:0] rom_wr_addr,
  input wire [WORD_W-1:0] rom_wr_data,
  // Port inputs and state
  input wire [3:0] port_in,
  output reg [PC_W-1:0] program_counter,
  output reg carry_flag,
  output reg [2:0] g_reg,
  output reg [WORD_W-1:0] data_reg,
  output reg halted,
  output reg [3:0] port_out_code,
  output reg [3:0] port_out_data,
  output reg port_out_stb
);
  // ==========================================
  // Storage
  reg [WORD_W-1:0] rom_mem [0:(1<<PC_W)-1]; // RULE8
  reg [3:0] ram_mem [0:127]; // RULE10
  reg [PC_W-1:0] stack_reg;
  wire init_lvl;
  wire inh_lvl;
  wire core_rst;
  wire [WORD_W-1:0] instr;
  wire [5:0] opcode;
  wire [1:0] f_row;
  wire [3:0] f_col;
  wire [3:0] f_lo;
  wire [6:0] mem_addr;
  wire [6:0] reg_addr;
  wire [6:0] ind_addr;
  wire [3:0] mem_val;
  wire [3:0] reg_val;
  wire [3:0] alu_res;
  wire alu_cout;
  wire alu_skip;
  wire alu_wc;
  reg [3:0] op_a;
  reg [3:0] op_b;
  reg [PC_W-1:0] pc_next;
  reg ram_we;
  reg [6:0] ram_waddr;
  reg [3:0] ram_wdata;
  reg is_reg_dst;
  // ==========================================
  // Pin synchronisers
  fbc_sync #(.RST_VAL(1'b1)) u_init_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_in(init_n_in),
    .level_out(init_lvl)
  );
  fbc_sync #(.RST_VAL(1'b0)) u_inh_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_in(inhibit_in),
    .level_out(inh_lvl)
  );
  assign core_rst = sys_rst | ~init_lvl; // RULE20
  // ==========================================
  // Fetch and field decode; ROM is read asynchronously for single-cycle execution
  assign instr = rom_mem[program_counter];
  assign opcode = instr[`FBC_IC_HI:`FBC_IC_LO]; // RULE18
  assign f_row = instr[`FBC_ROW_HI:`FBC_ROW_LO];
  assign f_col = instr[`FBC_COL_HI:`FBC_COL_LO];
  assign f_lo = instr[`FBC_LO_HI:`FBC_LO_LO];
  // Direct operand reaches rows 0 to 3 only; upper rows need G
  assign mem_addr = {1'b0, f_row, f_col};
  assign reg_addr = {3'h0, f_lo}; // RULE12
  assign ind_addr = {g_reg, f_col}; // RULE11
  assign mem_val = ram_mem[mem_addr];
  assign reg_val = ram_mem[reg_addr];
  // ==========================================
  // ALU operand select: immediate forms use the low field, r,M forms the register
  always @* begin
    op_a = mem_val;
    op_b = f_lo;
    is_reg_dst = 1'b0;
    case (opcode)
      `OP_AD, `OP_ADS, `OP_ADN, `OP_SU, `OP_SUS, `OP_SUN, `OP_ORR, `OP_ANDR,
      `OP_AC, `OP_ACS, `OP_ACN, `OP_SB, `OP_SBS, `OP_SBN, `OP_LESS_THAN_SKIP, `OP_SGE,
      `OP_SEQ, `OP_SNE, `OP_TMTR, `OP_TMFR: begin
        op_a = reg_val;
        op_b = mem_val;
        is_reg_dst = 1'b1;
      end
      default: begin
        op_a = mem_val;
        op_b = f_lo;
      end
    endcase
  end
  fbc_alu u_alu (
    .opcode(opcode),
    .op_a(op_a),
    .op_b(op_b),
    .carry_in(carry_flag),
    .result(alu_res),
    .carry_out(alu_cout),
    .skip_cond(alu_skip),
    .writes_carry(alu_wc)
  );
  // ==========================================
  // Next program counter and memory write selection
  always @* begin
    pc_next = program_counter + {{(PC_W-1){1'b0}}, 1'b1}; // RULE2
    ram_we = 1'b0;
    ram_waddr = mem_addr;
    ram_wdata = alu_res;
    case (opcode)
      `OP_JUMP, `OP_CAL: pc_next = instr[`FBC_ADDR_HI:`FBC_ADDR_LO]; // RULE2
      `OP_RETURN: pc_next = stack_reg; // RULE5
      `OP_RETURN_SKIP: pc_next = stack_reg + {{(PC_W-1){1'b0}}, 1'b1}; // RULE5
      `OP_AI, `OP_ADD_IMM_SKIP, `OP_AIN, `OP_SI, `OP_SIS, `OP_SIN, `OP_AIC, `OP_AICS,
      `OP_AICN, `OP_SIB, `OP_SIBS, `OP_SIBN, `OP_ORIM, `OP_ANIM,
      `OP_AD, `OP_ADS, `OP_ADN, `OP_SU, `OP_SUS, `OP_SUN, `OP_ORR, `OP_ANDR,
      `OP_AC, `OP_ACS, `OP_ACN, `OP_SB, `OP_SBS, `OP_SBN: begin
        ram_we = 1'b1; // RULE7
        ram_waddr = is_reg_dst ? reg_addr : mem_addr;
      end
      `OP_LD: begin
        ram_we = 1'b1;
        ram_waddr = reg_addr;
        ram_wdata = mem_val;
      end
      `OP_ST: begin
        ram_we = 1'b1;
        ram_wdata = reg_val;
      end
      `OP_MVIM: begin
        ram_we = 1'b1;
        ram_wdata = f_lo;
      end
      `OP_INDIRECT_LOAD: begin
        ram_we = 1'b1;
        ram_waddr = reg_addr;
        ram_wdata = ram_mem[ind_addr]; // RULE13
      end
      `OP_INDIRECT_STORE: begin
        ram_we = 1'b1;
        ram_waddr = ind_addr; // RULE13
        ram_wdata = reg_val;
      end
      `OP_KEY: begin
        ram_we = 1'b1;
        // Port code picks which nibble of the data register lands in memory
        ram_wdata = data_reg[{f_lo[1:0], 2'b00} +: 4]; // RULE15
      end
      default: ram_we = 1'b0; // RULE22
    endcase
    if (alu_skip || (opcode == `OP_RETURN_SKIP)) begin
      // Return-with-skip lands one past the saved address
      if (opcode != `OP_RETURN_SKIP) begin
        pc_next = program_counter + {{(PC_W-2){1'b0}}, 2'b10}; // RULE3
      end
    end
  end
  // ==========================================
  // Execute: one instruction per enabled cycle, frozen while halted
  always @(posedge sys_clk) begin
    if (core_rst) begin
      program_counter <= `FBC_PC_RST; // RULE1
      stack_reg <= `FBC_PC_RST;
      carry_flag <= 1'b0;
      g_reg <= `FBC_G_RST;
      data_reg <= `FBC_DATA_RST;
      halted <= 1'b0;
      port_out_code <= 4'h0;
      port_out_data <= 4'h0;
      port_out_stb <= 1'b0;
    end else if (clk_en) begin
      port_out_stb <= 1'b0;
      if (halted) begin
        // Leaving inhibit-low state wakes the core; clock gating is outside
        if (inh_lvl) begin
          halted <= 1'b0;
        end
      end else begin
        program_counter <= pc_next;
        if (alu_wc) begin
          carry_flag <= alu_cout; // RULE16
        end
        case (opcode)
          `OP_CAL: stack_reg <= program_counter + {{(PC_W-1){1'b0}}, 1'b1}; // RULE4 RULE6
          `OP_TABLE_READ: data_reg <= rom_mem[{instr[`FBC_ROW_HI:`FBC_COL_LO], f_lo}]; // RULE9
          `OP_IO: begin
            // Port code sits in the low field; row and column pick the source word
            if (f_lo == `FBC_PORT_G) begin
              g_reg <= mem_val[2:0]; // RULE14
            end
            port_out_code <= f_lo;
            port_out_data <= mem_val;
            port_out_stb <= 1'b1;
          end
          `OP_CLOCK_HALT: begin
            if (!inh_lvl) begin
              halted <= 1'b1; // RULE21
            end
          end
          default: port_out_stb <= 1'b0;
        endcase
      end
    end
  end
  // ==========================================
  // RAM and ROM writes; RAM has no reset so contents survive clock halt
  always @(posedge sys_clk) begin
    if (clk_en && !core_rst && !halted && ram_we) begin
      ram_mem[ram_waddr] <= ram_wdata;
    end
    if (rom_wr_en) begin
      rom_mem[rom_wr_addr] <= rom_wr_data;
    end
  end
endmodule
`default_nettype wire

// file: fbc_core_asserts.sv
// Checker for fbc_core: reset, halt and G register behaviour at the ports.
// Assumes a bind to each fbc_core; one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "fbc_consts.vh"
// ==========================================
// Checker
module fbc_core_asserts #(
  parameter PC_W = 10,
  parameter WORD_W = 16
) (
  // Clock, reset, pin
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic init_n_in,
  // State
  input wire logic [PC_W-1:0] program_counter,
  input wire logic carry_flag,
  input wire logic [2:0] g_reg,
  input wire logic [WORD_W-1:0] data_reg,
  input wire logic halted,
  input wire logic [3:0] port_out_code,
  input wire logic [3:0] port_out_data,
  input wire logic port_out_stb
);
  // Reset lands on the next edge
  property p_rst_pc;
    @(posedge sys_clk) sys_rst |=> program_counter == '0;
  endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("pc not cleared");
  property p_rst_regs;
    @(posedge sys_clk) sys_rst |=> !carry_flag && !halted && g_reg == 3'h0 && !port_out_stb;
  endproperty
  a_rst_regs: assert property (p_rst_regs) else $error("state not cleared");
  // Two halted samples in a row mean no instruction ran between them
  property p_halt_pc;
    @(posedge sys_clk) disable iff (sys_rst) halted ##1 halted |-> $stable(program_counter);
  endproperty
  a_halt_pc: assert property (p_halt_pc) else $error("pc moved in halt");
  property p_halt_regs;
    @(posedge sys_clk) disable iff (sys_rst)
      halted ##1 halted |-> $stable(carry_flag) && $stable(g_reg) && $stable(data_reg);
  endproperty
  a_halt_regs: assert property (p_halt_regs) else $error("state moved in halt");
  // Only the port output may load a nonzero row pointer
  property p_g_only;
    @(posedge sys_clk) disable iff (sys_rst) $changed(g_reg) && g_reg != 3'h0 |-> port_out_stb;
  endproperty
  a_g_only: assert property (p_g_only) else $error("g changed without io");
  property p_g_io;
    @(posedge sys_clk) disable iff (sys_rst)
      port_out_stb && port_out_code == `FBC_PORT_G |-> g_reg == port_out_data[2:0];
  endproperty
  a_g_io: assert property (p_g_io) else $error("g not loaded");
  // Synchroniser delay is covered by the eight-sample hold
  property p_init_pc;
    @(posedge sys_clk) disable iff (sys_rst) !init_n_in [*8] |-> program_counter == '0;
  endproperty
  a_init_pc: assert property (p_init_pc) else $error("init did not clear pc");
  property p_init_cy;
    @(posedge sys_clk) disable iff (sys_rst) !init_n_in [*8] |-> !carry_flag && !halted;
  endproperty
  a_init_cy: assert property (p_init_cy) else $error("init did not clear flags");
endmodule
bind fbc_core fbc_core_asserts #(.PC_W(PC_W), .WORD_W(WORD_W)) u_fbc_core_asserts (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .init_n_in(init_n_in),
  .program_counter(program_counter), .carry_flag(carry_flag), .g_reg(g_reg),
  .data_reg(data_reg), .halted(halted), .port_out_code(port_out_code),
  .port_out_data(port_out_data), .port_out_stb(port_out_stb));
`default_nettype wire

// file: fbc_core_tb_top.sv
// Testbench for fbc_core: loads small programs and checks the run.
// Assumes rom[0] runs at the first enabled edge after reset ends.
`timescale 1ns/10ps
`default_nettype none
`include "fbc_consts.vh"
module fbc_core_tb_top;
  // ==========================================
  // Signals
  logic sys_clk, sys_rst, clk_en, init_n_in, inhibit_in, rom_wr_en;
  logic [9:0] rom_wr_addr;
  logic [15:0] rom_wr_data;
  logic [3:0] port_in;
  wire [9:0] program_counter;
  wire [2:0] g_reg;
  wire [15:0] data_reg;
  wire [3:0] port_out_code, port_out_data;
  wire carry_flag, halted, port_out_stb;
  int fails, n_tests, seed, k;
  logic [3:0] a, b, c;
  logic [4:0] sum;
  logic [15:0] w;
  logic [9:0] pc0;
  localparam logic [15:0] NOP = {`OP_NO_OPERATION, 10'h000};
  fbc_core u_fbc_core (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .init_n_in(init_n_in),
    .inhibit_in(inhibit_in), .rom_wr_en(rom_wr_en), .rom_wr_addr(rom_wr_addr),
    .rom_wr_data(rom_wr_data), .port_in(port_in), .program_counter(program_counter),
    .carry_flag(carry_flag), .g_reg(g_reg), .data_reg(data_reg), .halted(halted),
    .port_out_code(port_out_code), .port_out_data(port_out_data),
    .port_out_stb(port_out_stb));
  // ==========================================
  // Tasks
  task automatic stop_test;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Reset stays high while the program is loaded
  task automatic hold_rst;
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(16'(program_counter), 16'h0, "rst pc");
  endtask
  task automatic put(input logic [9:0] ad, input logic [15:0] d);
    @(posedge sys_clk);
    rom_wr_en <= 1'b1;
    rom_wr_addr <= ad;
    rom_wr_data <= d;
  endtask
  // Bounded wait for the first instruction to retire
  task automatic wait_pc1;
    int i;
    for (i = 0; i < 12 && program_counter !== 10'h001; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(16'(program_counter), 16'h1, "start");
    if (program_counter !== 10'h001) begin
      stop_test();
    end
  endtask
  task automatic go;
    @(posedge sys_clk);
    rom_wr_en <= 1'b0;
    sys_rst <= 1'b0;
    port_in <= 4'($random(seed));
    wait_pc1();
  endtask
  task automatic step(input logic [9:0] pc);
    @(posedge sys_clk);
    #1;
    chk(16'(program_counter), 16'(pc), "pc");
  endtask
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    init_n_in = 1'b1;
    inhibit_in = 1'b1;
    rom_wr_en = 1'b0;
    rom_wr_addr = 10'h000;
    rom_wr_data = 16'h0000;
    port_in = 4'h0;
    fails = 0;
    n_tests = 0;
    seed = 31710;
    repeat (2) @(posedge sys_clk);
    // Flow: unassigned codes, far jump, nested calls, both returns
    hold_rst();
    put(10'h000, NOP);
    put(10'h001, {`OP_UND0, 10'h155});
    put(10'h002, {`OP_UND1, 10'h2aa});
    put(10'h003, {`OP_JUMP, 10'h3ff});
    put(10'h3ff, {`OP_CAL, 10'h010});
    put(10'h010, {`OP_CAL, 10'h020});
    put(10'h020, {`OP_RETURN, 10'h000});
    put(10'h011, {`OP_RETURN_SKIP, 10'h000});
    go();
    step(10'h002);
    step(10'h003);
    step(10'h3ff);
    step(10'h010);
    step(10'h020);
    step(10'h011);
    step(10'h012);
    chk(16'(carry_flag), 16'h0, "carry");
    // Add with skip, subtract immediate setting borrow, carry held; first two are edges
    for (k = 0; k < 12; k++) begin
      a = 4'($random(seed));
      b = 4'($random(seed));
      c = 4'($random(seed));
      if (k < 2) begin
        a = 4'hf;
        b = (k == 0) ? 4'h1 : 4'h0;
      end
      sum = {1'b0, a} + {1'b0, b};
      hold_rst();
      put(10'h000, NOP);
      put(10'h001, {`OP_MVIM, 2'h0, 4'h1, a});
      put(10'h002, {`OP_ADD_IMM_SKIP, 2'h0, 4'h1, b});
      put(10'h003, NOP);
      put(10'h004, {`OP_SI, 2'h0, 4'h1, c});
      put(10'h005, {`OP_MVIM, 2'h0, 4'h2, a});
      put(10'h006, NOP);
      go();
      step(10'h002);
      step(sum[4] ? 10'h004 : 10'h003);
      chk(16'(carry_flag), 16'(sum[4]), "add carry");
      if (!sum[4]) begin
        step(10'h004);
      end
      step(10'h005);
      chk(16'(carry_flag), 16'(sum[3:0] < c), "borrow");
      step(10'h006);
      chk(16'(carry_flag), 16'(sum[3:0] < c), "held");
    end
    // Table read, row pointer load, halt refused while inhibit high
    hold_rst();
    w = 16'($random(seed));
    a = 4'($random(seed));
    put(10'h000, NOP);
    put(10'h001, {`OP_TABLE_READ, 10'h3a5});
    put(10'h3a5, w);
    put(10'h002, {`OP_MVIM, 2'h0, 4'h3, a});
    put(10'h003, {`OP_IO, 2'h0, 4'h3, `FBC_PORT_G});
    put(10'h004, {`OP_CLOCK_HALT, 10'h000});
    go();
    step(10'h002);
    chk(data_reg, w, "table word");
    step(10'h003);
    step(10'h004);
    chk(16'({port_out_stb, g_reg}), 16'({1'b1, a[2:0]}), "g reg");
    step(10'h005);
    chk(16'({halted, port_out_stb}), 16'h0, "no halt");
    // Halt with inhibit low, wake, then initialize pin
    hold_rst();
    inhibit_in <= 1'b0;
    put(10'h000, NOP);
    put(10'h001, {`OP_CLOCK_HALT, 10'h000});
    put(10'h002, {`OP_JUMP, 10'h002});
    go();
    @(posedge sys_clk);
    #1;
    pc0 = program_counter;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(16'({halted, program_counter}), 16'({1'b1, pc0}), "halt");
    inhibit_in <= 1'b1;
    for (k = 0; k < 12 && halted !== 1'b0; k++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(16'(halted), 16'h0, "wake");
    init_n_in <= 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    chk(16'({carry_flag, program_counter}), 16'h0, "init");
    init_n_in <= 1'b1;
    wait_pc1();
    stop_test();
  end
endmodule
`default_nettype wire

// file: fbc_sync.v
// Three-stage input synchroniser for pins from outside the clock domain.
// Assumes one clock; output changes once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module fbc_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  // Pin and clean level
  input wire pin_in,
  output reg level_out
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  // ==========================================
  // Shift chain; stage one feeds only stage two
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      level_out <= RST_VAL;
    end else if (clk_en) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg; // Filters a one-cycle glitch
      end
    end
  end
endmodule
`default_nettype wire
